/* pdc_powerdown_control_bank.sv */
// power-down control bank: two control registers and derived unit enables
`timescale 1ns/1ps
// one control register: address match, write mask and reset value
module pdc_ctrl_reg
   import pdc_pkg::*;
#(
   parameter logic [ADDR_W-1:0] REG_ADDR = '0,
   parameter logic [REG_W-1:0] REG_MASK = '0,
   parameter logic [REG_W-1:0] REG_RESET = '0
)
(
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // write port from the serial control logic
   input wire logic wr_en_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [REG_W-1:0] wdata_i,
   // address match and stored contents
   output logic hit_o,
   output logic [REG_W-1:0] value_o
);
   logic hit;
   logic [REG_W-1:0] value;
   logic [REG_W-1:0] next_value;

   // masked write, unwritable bits always store zero
   always_comb begin
      hit = addr_i == REG_ADDR;
      next_value = value;
      if (wr_en_i && hit) begin
         next_value = wdata_i & REG_MASK;
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         value <= REG_RESET;
      end else begin
         value <= next_value;
      end
   end

   assign hit_o = hit;
   assign value_o = value;
endmodule : pdc_ctrl_reg

// one unit enable: low under master sleep or the unit's own sleep bits
module pdc_unit_gate #(
   parameter int unsigned UNIT_W = 1
)
(
   // sleep controls
   input wire logic master_sleep_i,
   input wire logic [UNIT_W-1:0] unit_sleep_i,
   // enable towards the unit
   output logic [UNIT_W-1:0] unit_en_o
);
   always_comb begin
      unit_en_o = '0;
      if (!master_sleep_i) begin
         unit_en_o = ~unit_sleep_i;
      end
   end
endmodule : pdc_unit_gate

module pdc_powerdown_control_bank
   import pdc_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // register write and read port from the serial control logic
   input wire logic wr_en_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [REG_W-1:0] wdata_i,
   output logic [REG_W-1:0] rdata_o,
   // unit enables
   output pdc_enables_t enables_o
);
   // stored registers and their address matches
   logic [REG_W-1:0] power_down_main;
   logic [REG_W-1:0] power_down_clocks_spdif;
   logic main_hit;
   logic clocks_hit;
   // sleep controls and gated unit enables
   logic master;
   logic [2:0] dac_sleep;
   logic adc_gated;
   logic [2:0] dac_gated;
   logic spdif_tx_gated;
   logic spdif_rx_gated;
   logic clock_recovery_gated;
   logic pll_a_gated;
   logic pll_b_gated;
   logic osc_output_gated;
   // registered enables
   pdc_enables_t enables;
   pdc_enables_t next_enables;

   pdc_ctrl_reg #(
      .REG_ADDR(ADDR_POWER_DOWN_MAIN),
      .REG_MASK(MAIN_MASK),
      .REG_RESET(MAIN_RESET)
   ) pdc_ctrl_reg_main_inst (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .wr_en_i(wr_en_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .hit_o(main_hit),
      .value_o(power_down_main)
   );

   pdc_ctrl_reg #(
      .REG_ADDR(ADDR_POWER_DOWN_CLOCKS_SPDIF),
      .REG_MASK(CLK_MASK),
      .REG_RESET(CLK_RESET)
   ) pdc_ctrl_reg_clocks_inst (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .wr_en_i(wr_en_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .hit_o(clocks_hit),
      .value_o(power_down_clocks_spdif)
   );

   // read back, unmapped addresses read as zero
   always_comb begin
      rdata_o = '0;
      if (main_hit) begin
         rdata_o = power_down_main;
      end else if (clocks_hit) begin
         rdata_o = power_down_clocks_spdif;
      end
   end

   // sleep fields, every-DAC bit overriding the per-DAC field
   always_comb begin
      master = power_down_main[BIT_MASTER_SLEEP];
      dac_sleep = power_down_main[BIT_PER_DAC_HI:BIT_PER_DAC_LO];
      if (power_down_main[BIT_EVERY_DAC_SLEEP]) begin
         dac_sleep = DAC_ALL_OFF;
      end
   end

   pdc_unit_gate #(
      .UNIT_W(1)
   ) pdc_unit_gate_adc_inst (
      .master_sleep_i(master),
      .unit_sleep_i(power_down_main[BIT_ADC_SLEEP]),
      .unit_en_o(adc_gated)
   );

   pdc_unit_gate #(
      .UNIT_W(3)
   ) pdc_unit_gate_dac_inst (
      .master_sleep_i(master),
      .unit_sleep_i(dac_sleep),
      .unit_en_o(dac_gated)
   );

   pdc_unit_gate #(
      .UNIT_W(1)
   ) pdc_unit_gate_spdif_tx_inst (
      .master_sleep_i(master),
      .unit_sleep_i(power_down_clocks_spdif[BIT_SPDIF_TX_SLEEP]),
      .unit_en_o(spdif_tx_gated)
   );

   pdc_unit_gate #(
      .UNIT_W(1)
   ) pdc_unit_gate_spdif_rx_inst (
      .master_sleep_i(master),
      .unit_sleep_i(power_down_clocks_spdif[BIT_SPDIF_RX_SLEEP]),
      .unit_en_o(spdif_rx_gated)
   );

   pdc_unit_gate #(
      .UNIT_W(1)
   ) pdc_unit_gate_recovery_inst (
      .master_sleep_i(master),
      .unit_sleep_i(power_down_clocks_spdif[BIT_CLOCK_RECOVERY_SLEEP]),
      .unit_en_o(clock_recovery_gated)
   );

   pdc_unit_gate #(
      .UNIT_W(1)
   ) pdc_unit_gate_pll_a_inst (
      .master_sleep_i(master),
      .unit_sleep_i(power_down_clocks_spdif[BIT_PLL_A_SLEEP]),
      .unit_en_o(pll_a_gated)
   );

   pdc_unit_gate #(
      .UNIT_W(1)
   ) pdc_unit_gate_pll_b_inst (
      .master_sleep_i(master),
      .unit_sleep_i(power_down_clocks_spdif[BIT_PLL_B_SLEEP]),
      .unit_en_o(pll_b_gated)
   );

   pdc_unit_gate #(
      .UNIT_W(1)
   ) pdc_unit_gate_osc_inst (
      .master_sleep_i(master),
      .unit_sleep_i(power_down_clocks_spdif[BIT_OSC_OUTPUT_SLEEP]),
      .unit_en_o(osc_output_gated)
   );

   // master sleep also stops digital logic, outputs and references
   always_comb begin
      next_enables = '0;
      next_enables.adc_en = adc_gated;
      next_enables.dac_en = dac_gated;
      next_enables.spdif_tx_en = spdif_tx_gated;
      next_enables.spdif_rx_en = spdif_rx_gated;
      next_enables.clock_recovery_en = clock_recovery_gated;
      next_enables.pll_a_en = pll_a_gated;
      next_enables.pll_b_en = pll_b_gated;
      next_enables.osc_output_en = osc_output_gated;
      next_enables.digital_run = !master;
      next_enables.outputs_active = !master;
      next_enables.reference_en = !master;
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         enables <= ENABLES_RESET;
      end else begin
         enables <= next_enables;
      end
   end

   assign enables_o = enables;
endmodule : pdc_powerdown_control_bank

/* pdc_pkg.sv */
// package for the power-down control bank: register map, fields, reset values
package pdc_pkg;
   localparam int unsigned REG_W = 9;
   localparam int unsigned ADDR_W = 7;
   localparam logic [ADDR_W-1:0] ADDR_POWER_DOWN_MAIN = 7'h32;
   localparam logic [ADDR_W-1:0] ADDR_POWER_DOWN_CLOCKS_SPDIF = 7'h33;
   // power_down_main fields
   localparam int unsigned BIT_MASTER_SLEEP = 0;
   localparam int unsigned BIT_ADC_SLEEP = 1;
   localparam int unsigned BIT_PER_DAC_LO = 2;
   localparam int unsigned BIT_PER_DAC_HI = 4;
   localparam int unsigned BIT_EVERY_DAC_SLEEP = 6;
   // power_down_clocks_spdif fields
   localparam int unsigned BIT_OSC_OUTPUT_SLEEP = 0;
   localparam int unsigned BIT_PLL_A_SLEEP = 1;
   localparam int unsigned BIT_PLL_B_SLEEP = 2;
   localparam int unsigned BIT_CLOCK_RECOVERY_SLEEP = 3;
   localparam int unsigned BIT_SPDIF_TX_SLEEP = 4;
   localparam int unsigned BIT_SPDIF_RX_SLEEP = 5;
   // writable bits and reset values
   localparam logic [REG_W-1:0] MAIN_MASK = 9'h05F;
   localparam logic [REG_W-1:0] CLK_MASK = 9'h03F;
   localparam logic [REG_W-1:0] MAIN_RESET = 9'h05E;
   localparam logic [REG_W-1:0] CLK_RESET = 9'h03E;
   localparam logic [2:0] DAC_ALL_OFF = 3'h7;

   typedef struct packed {
      logic adc_en;
      logic [2:0] dac_en;
      logic spdif_tx_en;
      logic spdif_rx_en;
      logic clock_recovery_en;
      logic pll_a_en;
      logic pll_b_en;
      logic osc_output_en;
      logic digital_run;
      logic outputs_active;
      logic reference_en;
   } pdc_enables_t;

   localparam pdc_enables_t ENABLES_RESET = '{adc_en: 1'b0, dac_en: 3'h0, spdif_tx_en: 1'b0,
      spdif_rx_en: 1'b0, clock_recovery_en: 1'b0, pll_a_en: 1'b0, pll_b_en: 1'b0,
      osc_output_en: 1'b1, digital_run: 1'b1, outputs_active: 1'b1, reference_en: 1'b1};
endpackage : pdc_pkg

/* pdc_powerdown_control_bank_monitor.sv */
// checker of unit enables against register contents
`timescale 1ns/1ps
module pdc_powerdown_control_bank_monitor
   import pdc_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [REG_W-1:0] rdata_o,
   input wire pdc_enables_t enables_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   logic [REG_W-1:0] pr;
   wire on_m = addr_i == ADDR_POWER_DOWN_MAIN;
   wire on_c = addr_i == ADDR_POWER_DOWN_CLOCKS_SPDIF;
   wire run = enables_o.digital_run;
   always_ff @(posedge clock_i) pr <= rdata_o;
   chk_adc_gate: assert property (on_m |=> enables_o.adc_en == !(pr[0] || pr[1])) else $error("adc");
   chk_dac_each: assert property (on_m |=> enables_o.dac_en == (~pr[4:2] & {3{!pr[6] && !pr[0]}}))
      else $error("dac");
   chk_every_dac: assert property (on_m && rdata_o[6] |=> enables_o.dac_en == 3'h0) else $error("all dac");
   chk_spdif_pair: assert property (on_c |=>
      {enables_o.spdif_tx_en, enables_o.spdif_rx_en} == ({2{run}} & ~{pr[4], pr[5]})) else $error("spdif");
   chk_pll_pair: assert property (on_c |=>
      {enables_o.pll_a_en, enables_o.pll_b_en} == ({2{run}} & ~{pr[1], pr[2]})) else $error("pll");
   chk_recovery_gate: assert property (on_c |=> enables_o.clock_recovery_en == (run && !pr[3]))
      else $error("recovery");
   chk_osc_gate: assert property (on_c |=> enables_o.osc_output_en == (run && !pr[0])) else $error("osc");
   chk_master_all: assert property (!run |-> enables_o == '0) else $error("master");
   chk_run_trio: assert property (on_m |=>
      {run, enables_o.outputs_active, enables_o.reference_en} == {3{!pr[0]}}) else $error("run");
endmodule : pdc_powerdown_control_bank_monitor
bind pdc_powerdown_control_bank pdc_powerdown_control_bank_monitor pdc_powerdown_control_bank_monitor_inst (
   .clock_i, .sys_rst_i, .addr_i, .rdata_o, .enables_o);

/* powerdown_control_bank_tb_top.sv */
// self-checking bench for the power-down control bank
`timescale 1ns/1ps
module powerdown_control_bank_tb_top;
   import pdc_pkg::*;
   `define CMP(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("mismatch %0t value", $time); end end
   logic clock_i = 0, sys_rst_i = 1, wr_en_i = 0;
   logic [ADDR_W-1:0] addr_i = ADDR_POWER_DOWN_MAIN;
   logic [REG_W-1:0] wdata_i = 9'h000, rdata_o, em = 9'h05E, ec = 9'h03E;
   pdc_enables_t enables_o;
   int fails = 0, samples_checked = 0, seed = 23713;
   always #50 clock_i = ~clock_i;
   pdc_powerdown_control_bank pdc_powerdown_control_bank_inst (.clock_i, .sys_rst_i, .wr_en_i, .addr_i, .wdata_i,
      .rdata_o, .enables_o);
   function automatic logic [12:0] expect_en(logic [REG_W-1:0] m, logic [REG_W-1:0] c);
      logic r;
      r = !m[0];
      return {r & !m[1], {3{r & !m[6]}} & ~m[4:2], ~{c[4], c[5], c[3], c[1], c[2], c[0]} & {6{r}}, {3{r}}};
   endfunction : expect_en
   task automatic write_reg(logic [ADDR_W-1:0] a, logic [REG_W-1:0] d);
      @(posedge clock_i);
      wr_en_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      if (a == 7'h32) em = d & 9'h05F;
      if (a == 7'h33) ec = d & 9'h03F;
   endtask : write_reg
   task automatic check_all();
      @(posedge clock_i);
      wr_en_i <= 1'b0;
      addr_i <= 7'h32;
      @(negedge clock_i);
      `CMP(rdata_o, em)
      @(posedge clock_i);
      addr_i <= 7'h33;
      @(negedge clock_i);
      `CMP(rdata_o, ec)
      `CMP(enables_o, expect_en(em, ec))
      @(posedge clock_i);
      addr_i <= 7'h31;
      @(negedge clock_i);
      `CMP(rdata_o, 9'h000)
   endtask : check_all
   task automatic wrap_up();
      $display("checked %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (2) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      check_all();
      write_reg(7'h32, 9'h000);
      write_reg(7'h33, 9'h000);
      check_all();
      write_reg(7'h32, 9'h040);
      check_all();
      write_reg(7'h32, 9'h1FF);
      check_all();
      write_reg(ADDR_POWER_DOWN_MAIN, 9'h05E);
      write_reg(ADDR_POWER_DOWN_MAIN, 9'h05F);
      check_all();
      write_reg(ADDR_POWER_DOWN_MAIN, 9'h001);
      write_reg(ADDR_POWER_DOWN_CLOCKS_SPDIF, 9'h000);
      check_all();
      repeat (80) begin
         write_reg(7'h31 + 7'($unsigned($random(seed)) % 3), 9'($random(seed)));
         if ($random(seed) & 1) check_all();
      end
      check_all();
      write_reg(ADDR_POWER_DOWN_MAIN, 9'h000);
      @(posedge clock_i);
      wr_en_i <= 1'b0;
      sys_rst_i <= 1'b1;
      em = 9'h05E;
      ec = 9'h03E;
      repeat (2) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      check_all();
      wrap_up();
   end
endmodule : powerdown_control_bank_tb_top
